// ==== pkg/fpt_pkg.sv ====
/*
  Constants for the two-channel fan speed output and tachometer monitor.
  Assumes a single 40 MHz system clock and an 8-bit register port.
*/
// Function
// - force bit holds speed output high
// - period of 64 slices, duty slices high
// - duty zero stays low, all ones 63/64
// - source and select pick base frequency
// - multiplier bit doubles the chosen frequency
// - output registers at 0x56 and 0x57
// - shared control register at 0x58
// - tach divisor 1, 2, 4, 8; default 2
// - count divided slow clock per tach period
// - restart count on tach rise or preload write
// - count saturates at 0xFF until restart
// - count 192 raises gated fan-failure event
// - restart loads programmed per-channel preload value
// - slow reference from pin or derived internally
// - two tach pulses per revolution assumed
// - speed outputs low after reset
// - status bit cleared only by writing one
package fpt_pkg;
  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int SLICES      = 64;
  localparam int F_FAST0_HZ  = 15625;
  localparam int F_FAST1_HZ  = 23438;
  localparam int F_SLOW0_HZ  = 40;
  localparam int F_SLOW1_HZ  = 60;
  localparam int F_REF_HZ    = 32768;
  localparam int FAST0_CYC   = CLK_HZ / (F_FAST0_HZ * SLICES);
  localparam int FAST1_CYC   = CLK_HZ / (F_FAST1_HZ * SLICES);
  localparam int SLOW0_CYC   = CLK_HZ / (F_SLOW0_HZ * SLICES);
  localparam int SLOW1_CYC   = CLK_HZ / (F_SLOW1_HZ * SLICES);
  localparam int REF_CYC     = CLK_HZ / F_REF_HZ;
  localparam logic [5:0] SLICE_LAST = 6'h3F;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_OUT_A  = 8'h56;
  localparam logic [7:0] OFS_OUT_B  = 8'h57;
  localparam logic [7:0] OFS_SHARED = 8'h58;
  localparam logic [7:0] OFS_PRE_A  = 8'h50;
  localparam logic [7:0] OFS_PRE_B  = 8'h51;
  localparam logic [7:0] OFS_CNT_A  = 8'h52;
  localparam logic [7:0] OFS_CNT_B  = 8'h53;
  localparam logic [7:0] OFS_CLKCFG = 8'h54;
  localparam logic [7:0] OFS_STAT   = 8'h55;
  localparam logic [7:0] OFS_MASK   = 8'h59;
  localparam logic [7:0] OFS_ROUTE  = 8'h5A;
  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] RST_OUT    = 8'h00;
  localparam logic [7:0] RST_SHARED = 8'h50;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam int OUT_SEL_BIT   = 7;
  localparam int OUT_DUTY_LSB  = 1;
  localparam int OUT_FORCE_BIT = 0;
  localparam int SH_DIV_A_LSB  = 4;
  localparam int SH_DIV_B_LSB  = 6;
  localparam int SH_MUL_A_BIT  = 2;
  localparam int SH_MUL_B_BIT  = 3;
  localparam int SH_SRC_A_BIT  = 0;
  localparam int SH_SRC_B_BIT  = 1;
  localparam logic [7:0] CNT_SAT    = 8'hFF;
  localparam logic [1:0] ALARM_MSBS = 2'h3;
endpackage : fpt_pkg

// ==== pkg/fpt_ch_if.sv ====
/*
  Per-channel carrier between the register file, the PWM and the tach counter.
  Assumes one instance per fan channel inside the top module.
*/
`timescale 1ns/1ps
interface fpt_ch_if;
  logic [5:0] duty_value;
  logic       force_hi;
  logic       clk_sel;
  logic       mult;
  logic       src;
  logic [1:0] divsel;
  logic [7:0] preload;
  logic       preload_wr;
  logic [7:0] count;
  logic       fail_evt;
  modport ctl  (output duty_value, force_hi, clk_sel, mult, src, divsel, preload, preload_wr,
                input count, fail_evt);
  modport pwm  (input duty_value, force_hi, clk_sel, mult, src);
  modport tach (input divsel, preload, preload_wr, output count, fail_evt);
endinterface : fpt_ch_if

// ==== rtl/fpt_pwm.sv ====
/*
  One fan speed output: 64-slice pulse width modulator with rate select.
  Assumes settings come from the register file on the same clock.
*/
`timescale 1ns/1ps
module fpt_pwm
  import fpt_pkg::*;
#(
  parameter int SLOW0 = SLOW0_CYC,
  parameter int SLOW1 = SLOW1_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  fpt_ch_if.pwm     p,
  output logic      o_pwm
);
  typedef struct packed {
    logic [15:0] pre;
    logic [15:0] div;
    logic [5:0]  slice;
    logic [5:0]  duty;
    logic        out;
  } fpt_pwm_st_t;

  fpt_pwm_st_t st_reg;
  fpt_pwm_st_t st_next;
  logic [15:0] base;
  logic        tick;
  logic        wrap;

  always_comb begin
    base = p.src ? (p.clk_sel ? 16'(SLOW1) : 16'(SLOW0))
                 : (p.clk_sel ? 16'(FAST1_CYC) : 16'(FAST0_CYC));
    if (p.mult) begin
      base = base >> 1;
    end
    tick    = (st_reg.pre == 16'h0000);
    wrap    = tick && (st_reg.slice == SLICE_LAST);
    st_next = st_reg;
    st_next.pre = st_reg.pre - 16'h0001;
    if (tick) begin
      st_next.slice = st_reg.slice + 6'h01;
      st_next.pre   = (wrap ? base : st_reg.div) - 16'h0001;
    end
    if (wrap) begin
      st_next.div  = base;
      st_next.duty = p.duty_value;
    end
    st_next.out = p.force_hi || (st_reg.slice < st_reg.duty);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '{pre: 16'h0000, div: 16'(FAST0_CYC), slice: SLICE_LAST, duty: 6'h00, out: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pwm = st_reg.out;

  a_force_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    p.force_hi |=> o_pwm) else $error("force bit did not hold output high");
  a_zero_duty_low: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!p.force_hi && st_reg.duty == 6'h00) |=> !o_pwm) else $error("zero duty drove output");
  a_slice_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.slice < st_reg.duty) |=> o_pwm) else $error("output low inside duty slices");
  a_slice_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    wrap |=> (st_reg.slice == 6'h00)) else $error("period not 64 slices");
  a_duty_at_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !$stable(st_reg.duty) |-> $past(wrap)) else $error("duty changed mid period");
endmodule : fpt_pwm

// ==== rtl/fpt_tach.sv ====
/*
  One tachometer counter: synchroniser, slow clock divider, saturating count.
  Assumes i_ref_tick is a one-cycle pulse at the slow reference rate.
*/
`timescale 1ns/1ps
module fpt_tach
  import fpt_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_tach,
  input  wire logic i_ref_tick,
  fpt_ch_if.tach    t
);
  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
    logic [2:0] divc;
    logic [7:0] cnt;
    logic       hit;
  } fpt_tach_st_t;

  fpt_tach_st_t st_reg;
  fpt_tach_st_t st_next;
  logic [3:0]   lim;
  logic         rise;
  logic         dtick;

  always_comb begin
    lim   = 4'(4'h1 << t.divsel) - 4'h1;
    rise  = st_reg.sync[1] && !st_reg.prev;
    dtick = i_ref_tick && ({1'b0, st_reg.divc} == lim);
    st_next      = st_reg;
    st_next.sync = {st_reg.sync[0], i_tach};
    st_next.prev = st_reg.sync[1];
    st_next.hit  = (st_reg.cnt[7:6] == ALARM_MSBS);
    if (rise || t.preload_wr) begin
      st_next.cnt  = t.preload;
      st_next.divc = 3'h0;
    end else if (i_ref_tick) begin
      st_next.divc = dtick ? 3'h0 : st_reg.divc + 3'h1;
      if (dtick && st_reg.cnt != CNT_SAT) begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign t.count    = st_reg.cnt;
  assign t.fail_evt = (st_reg.cnt[7:6] == ALARM_MSBS) && !st_reg.hit;

  sequence s_restart;
    rise || t.preload_wr;
  endsequence
  a_restart_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_restart |=> (st_reg.cnt == $past(t.preload))) else $error("restart did not load preload");
  a_saturate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.cnt == CNT_SAT && !rise && !t.preload_wr) |=> (st_reg.cnt == CNT_SAT))
    else $error("count wrapped past saturation");
  a_fail_on_msbs: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    t.fail_evt |-> (st_reg.cnt >= 8'hC0)) else $error("failure event below threshold");
endmodule : fpt_tach

// ==== rtl/fpt_top.sv ====
/*
  Two-channel fan speed output and tachometer monitor with register port.
  Assumes a plain register master on i_sys_clk; pins arrive asynchronously.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module fpt_top
  import fpt_pkg::*;
#(
  parameter int SLOW0 = SLOW0_CYC,
  parameter int SLOW1 = SLOW1_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_slow_clock_pin,
  input  wire logic       i_tacho_input_a,
  input  wire logic       i_tacho_input_b,
  output logic            o_speed_output_a,
  output logic            o_speed_output_b,
  output logic            o_wake_request_n,
  output logic            o_sysmgmt_req,
  output logic            o_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  out_a;
    logic [7:0]  out_b;
    logic [7:0]  shared;
    logic [7:0]  pre_a;
    logic [7:0]  pre_b;
    logic [7:0]  clkcfg;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [3:0]  route;
    logic [7:0]  rdata;
    logic [2:0]  pin;
    logic [11:0] refc;
  } fpt_top_st_t;

  fpt_top_st_t st_reg;
  fpt_top_st_t st_next;
  logic        ref_tick;
  logic [1:0]  evt;
  logic [1:0]  clr;

  fpt_ch_if ch_a ();
  fpt_ch_if ch_b ();

  // ****************************************
  // register file and slow reference
  // ****************************************
  always_comb begin
    st_next     = st_reg;
    st_next.pin = {st_reg.pin[1:0], i_slow_clock_pin};
    st_next.refc = (st_reg.refc == 12'h000) ? 12'(REF_CYC - 1) : st_reg.refc - 12'h001;
    ref_tick = st_reg.clkcfg[0] ? (st_reg.pin[1] && !st_reg.pin[2])
                                : (st_reg.refc == 12'h000);
    evt = {ch_b.fail_evt, ch_a.fail_evt};
    clr = 2'h0;
    if (i_wr) begin
      unique case (i_addr)
        OFS_OUT_A:  st_next.out_a  = i_wdata;
        OFS_OUT_B:  st_next.out_b  = i_wdata;
        OFS_SHARED: st_next.shared = i_wdata;
        OFS_PRE_A:  st_next.pre_a  = i_wdata;
        OFS_PRE_B:  st_next.pre_b  = i_wdata;
        OFS_CLKCFG: st_next.clkcfg = {7'h00, i_wdata[0]};
        OFS_STAT:   clr            = i_wdata[1:0];
        OFS_MASK:   st_next.mask   = i_wdata[1:0];
        OFS_ROUTE:  st_next.route  = i_wdata[3:0];
        default:    st_next.rdata  = st_reg.rdata;
      endcase
    end
    st_next.stat  = (st_reg.stat & ~clr) | evt;
    st_next.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        OFS_OUT_A:  st_next.rdata = st_reg.out_a;
        OFS_OUT_B:  st_next.rdata = st_reg.out_b;
        OFS_SHARED: st_next.rdata = st_reg.shared;
        OFS_PRE_A:  st_next.rdata = st_reg.pre_a;
        OFS_PRE_B:  st_next.rdata = st_reg.pre_b;
        OFS_CNT_A:  st_next.rdata = ch_a.count;
        OFS_CNT_B:  st_next.rdata = ch_b.count;
        OFS_CLKCFG: st_next.rdata = st_reg.clkcfg;
        OFS_STAT:   st_next.rdata = {6'h00, st_reg.stat};
        OFS_MASK:   st_next.rdata = {6'h00, st_reg.mask};
        OFS_ROUTE:  st_next.rdata = {4'h0, st_reg.route};
        default:    st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '{out_a: RST_OUT, out_b: RST_OUT, shared: RST_SHARED, pre_a: RST_BYTE,
                  pre_b: RST_BYTE, clkcfg: RST_BYTE, stat: 2'h0, mask: 2'h0, route: 4'h0,
                  rdata: RST_BYTE, pin: 3'h0, refc: 12'h000};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // channel wiring
  // ****************************************
  assign ch_a.duty_value = st_reg.out_a[OUT_DUTY_LSB +: 6];
  assign ch_a.force_hi   = st_reg.out_a[OUT_FORCE_BIT];
  assign ch_a.clk_sel    = st_reg.out_a[OUT_SEL_BIT];
  assign ch_a.mult       = st_reg.shared[SH_MUL_A_BIT];
  assign ch_a.src        = st_reg.shared[SH_SRC_A_BIT];
  assign ch_a.divsel     = st_reg.shared[SH_DIV_A_LSB +: 2];
  assign ch_a.preload    = ch_a.preload_wr ? i_wdata : st_reg.pre_a;
  assign ch_a.preload_wr = i_wr && (i_addr == OFS_PRE_A);
  assign ch_b.duty_value = st_reg.out_b[OUT_DUTY_LSB +: 6];
  assign ch_b.force_hi   = st_reg.out_b[OUT_FORCE_BIT];
  assign ch_b.clk_sel    = st_reg.out_b[OUT_SEL_BIT];
  assign ch_b.mult       = st_reg.shared[SH_MUL_B_BIT];
  assign ch_b.src        = st_reg.shared[SH_SRC_B_BIT];
  assign ch_b.divsel     = st_reg.shared[SH_DIV_B_LSB +: 2];
  assign ch_b.preload    = ch_b.preload_wr ? i_wdata : st_reg.pre_b;
  assign ch_b.preload_wr = i_wr && (i_addr == OFS_PRE_B);

  fpt_pwm #(.SLOW0(SLOW0), .SLOW1(SLOW1)) u_pwm_a (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .p         (ch_a.pwm),
    .o_pwm     (o_speed_output_a)
  );
  fpt_pwm #(.SLOW0(SLOW0), .SLOW1(SLOW1)) u_pwm_b (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .p         (ch_b.pwm),
    .o_pwm     (o_speed_output_b)
  );
  fpt_tach u_tach_a (
    .i_sys_clk  (i_sys_clk),
    .i_resetn   (i_resetn),
    .i_tach     (i_tacho_input_a),
    .i_ref_tick (ref_tick),
    .t          (ch_a.tach)
  );
  fpt_tach u_tach_b (
    .i_sys_clk  (i_sys_clk),
    .i_resetn   (i_resetn),
    .i_tach     (i_tacho_input_b),
    .i_ref_tick (ref_tick),
    .t          (ch_b.tach)
  );

  // ****************************************
  // event routing
  // ****************************************
  assign o_rdata          = st_reg.rdata;
  assign o_irq            = |(st_reg.stat & st_reg.mask);
  assign o_wake_request_n = ~|(st_reg.stat & st_reg.route[1:0]);
  assign o_sysmgmt_req    = |(st_reg.stat & st_reg.route[3:2]);

  a_status_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.stat[0] && !(i_wr && i_addr == OFS_STAT && i_wdata[0])) |=> st_reg.stat[0])
    else $error("status bit dropped without write of one");
  a_event_wins: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ch_a.fail_evt |=> st_reg.stat[0]) else $error("failure event lost");
  a_read_idle_zero: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !$past(i_rd) |-> (o_rdata == 8'h00)) else $error("read data outside read cycle");
  a_write_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_wr && i_addr == OFS_OUT_A) |=> (st_reg.out_a == $past(i_wdata)))
    else $error("output register write lost");
  a_write_shared: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_wr && i_addr == OFS_SHARED) |=> (st_reg.shared == $past(i_wdata)))
    else $error("shared control write lost");
endmodule : fpt_top

// ==== test/fpt_fan_model.sv ====
/*
  Fan model: tach output toggling at a set half period while running.
  Assumes the bench gives the half period in system clock cycles.
*/
`timescale 1ns/1ps
module fpt_fan_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_half,
  output logic             o_tach
);
  logic [15:0] cnt_reg;
  // stopped fan holds its tach line low
  always @(posedge i_sys_clk) begin
    if (!i_run) begin
      cnt_reg <= 16'h0000;
      o_tach  <= 1'b0;
    end else if (cnt_reg >= i_half) begin
      cnt_reg <= 16'h0000;
      o_tach  <= ~o_tach;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule : fpt_fan_model

// ==== test/tb.sv ====
/*
  Self-checking bench for the fan speed output and tachometer monitor.
  Assumes a 40 MHz clock, fan models on both tach pins, a gated slow clock pin.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb
  import fpt_pkg::*;
;
  localparam int SL0 = 40;
  localparam int SL1 = 30;
  logic       i_sys_clk        = 1'b0;
  logic       i_resetn         = 1'b0;
  logic [7:0] i_addr           = 8'h00;
  logic [7:0] i_wdata          = 8'h00;
  logic       i_wr             = 1'b0;
  logic       i_rd             = 1'b0;
  logic       slow_ph          = 1'b0;
  logic       pin_on           = 1'b0;
  logic       i_slow_clock_pin;
  logic       run_a            = 1'b0;
  logic       run_b            = 1'b0;
  logic       rd_d1            = 1'b0;
  logic [7:0] o_rdata;
  logic       tach_a;
  logic       tach_b;
  logic       o_speed_output_a;
  logic       o_speed_output_b;
  logic       o_wake_request_n;
  logic       o_sysmgmt_req;
  logic       o_irq;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  logic [7:0] w_exp;
  logic [5:0] da;
  logic [5:0] db;
  int         n_errors = 0;
  int         n_checks = 0;
  int         ha;
  int         hb;
  int         sl;

  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  initial forever #15259 slow_ph = ~slow_ph;
  // oscillator present only while pin_on is set
  assign i_slow_clock_pin = slow_ph && pin_on;

  fpt_top #(.SLOW0(SL0), .SLOW1(SL1)) DUT (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slow_clock_pin(i_slow_clock_pin),
    .i_tacho_input_a(tach_a), .i_tacho_input_b(tach_b), .o_speed_output_a(o_speed_output_a),
    .o_speed_output_b(o_speed_output_b), .o_wake_request_n(o_wake_request_n),
    .o_sysmgmt_req(o_sysmgmt_req), .o_irq(o_irq)
  );
  fpt_fan_model u_fan_a (.i_sys_clk(i_sys_clk), .i_run(run_a), .i_half(16'h012C), .o_tach(tach_a));
  fpt_fan_model u_fan_b (.i_sys_clk(i_sys_clk), .i_run(run_b), .i_half(16'h03E8), .o_tach(tach_b));

  // ****************************************
  // read data watcher
  // ****************************************
  always @(posedge i_sys_clk) begin
    rd_d1 <= i_rd;
    if (rd_d1) begin
      w_exp = exp_q.pop_front();
      `CHK("read data", w_exp, o_rdata)
    end
  end

  // ****************************************
  // bus and helper tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    exp_q.push_back(x);
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  task automatic meas(input int n, output int a, output int b);
    a = 0;
    b = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      if (o_speed_output_a === 1'b1) a++;
      if (o_speed_output_b === 1'b1) b++;
    end
  endtask : meas

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #3_000_000;
    n_errors++;
    $display("[FAIL] run time exp within limit got limit");
    wrap_up();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    ha = $urandom(32'h4ae8_6283);
    repeat (6) @(posedge i_sys_clk);
    `CHK("speed a in reset", 1'b0, o_speed_output_a)
    `CHK("speed b in reset", 1'b0, o_speed_output_b)
    i_resetn <= 1'b1;
    run_b    <= 1'b1;
    rd(OFS_OUT_A, RST_OUT);
    rd(OFS_OUT_B, RST_OUT);
    rd(OFS_SHARED, 8'h50);
    rd(OFS_STAT, 8'h00);
    wr(8'h7F, 8'hA5);
    rd(8'h7F, 8'h00);
    e = 8'($urandom);
    wr(OFS_OUT_B, e);
    rd(OFS_OUT_B, e);
    $display("test register map done");
    // all eight rate modes, duty on both channels
    for (int m = 0; m < 8; m++) begin
      da = (m == 0) ? 6'h00 : 6'($urandom_range(62, 1));
      db = (m == 0) ? 6'h3F : 6'($urandom_range(62, 1));
      sl = m[1] ? (m[0] ? SL1 : SL0) : (m[0] ? FAST1_CYC : FAST0_CYC);
      sl = m[2] ? sl / 2 : sl;
      wr(OFS_SHARED, {4'h5, m[2], m[2], m[1], m[1]});
      wr(OFS_OUT_A, {m[0], da, 1'b0});
      wr(OFS_OUT_B, {m[0], db, 1'b0});
      cyc(SLICES * SL0 + 16);
      meas(SLICES * sl, ha, hb);
      `CHK("duty a", int'(da) * sl, ha)
      `CHK("duty b", int'(db) * sl, hb)
    end
    wr(OFS_OUT_A, 8'h0B);
    cyc(4);
    meas(SLICES * SL0, ha, hb);
    `CHK("force high", SLICES * SL0, ha)
    $display("test pwm done");
    // steady fan holds no alarm, stopped fan raises it
    wr(OFS_SHARED, 8'h40);
    wr(OFS_MASK, 8'h01);
    wr(OFS_ROUTE, 8'h05);
    run_a <= 1'b1;
    wr(OFS_PRE_A, 8'hBE);
    cyc(8000);
    rd(OFS_STAT, 8'h00);
    `CHK("irq idle", 1'b0, o_irq)
    run_a <= 1'b0;
    cyc(3500);
    `CHK("irq", 1'b1, o_irq)
    `CHK("wake", 1'b0, o_wake_request_n)
    `CHK("sysmgmt", 1'b1, o_sysmgmt_req)
    wr(OFS_MASK, 8'h00);
    cyc(1);
    `CHK("irq masked", 1'b0, o_irq)
    wr(OFS_STAT, 8'h00);
    rd(OFS_STAT, 8'h01);
    wr(OFS_STAT, 8'h01);
    rd(OFS_STAT, 8'h00);
    `CHK("wake cleared", 1'b1, o_wake_request_n)
    $display("test alarm done");
    // pin reference chosen while the pin is silent freezes the count
    wr(OFS_CLKCFG, 8'h01);
    wr(OFS_PRE_A, 8'hFA);
    cyc(2);
    rd(OFS_CNT_A, 8'hFA);
    cyc(2500);
    rd(OFS_CNT_A, 8'hFA);
    // running pin drives the count into saturation
    pin_on <= 1'b1;
    cyc(7500);
    rd(OFS_CNT_A, 8'hFF);
    wr(OFS_PRE_A, 8'hBE);
    cyc(3500);
    rd(OFS_STAT, 8'h01);
    // divide by eight slows the count
    wr(OFS_STAT, 8'h01);
    wr(OFS_SHARED, 8'h70);
    wr(OFS_PRE_A, 8'hBE);
    cyc(3500);
    rd(OFS_STAT, 8'h00);
    cyc(18500);
    rd(OFS_STAT, 8'h01);
    $display("test tach done");
    wrap_up();
  end
endmodule : tb
